// file: apdc_consts.vh
// constants for the converter power-mode and output-drive control block
// assumes a 40 MHz clock and a write-only three-wire serial configuration port
// Function
// - writing one to the reset bit restores all registers; the bit self-clears
// - each per-channel sleep bit puts only its own channel into light sleep
// - deep sleep powers down all channels but keeps bit and frame clocks running
// - full power-down switches off the whole chip including the band-gap
// - in full power-down the bit and frame clock outputs go high impedance
// - pin function low bit one: pin high puts every channel in light sleep
// - pin function binary 10: pin high enters deep sleep
// - pin function binary 00 (default): pin high enters full power-down
// - the power-down pin acts on all channels together, never one by one
// - sleeping with driver mode low: data drivers powered down, outputs high impedance
// - sleeping with driver mode high: data drivers stay on and output zero
// - driver mode never touches clock drivers; they stay on in both sleeps
// - drive code maps 000=3.5,001=2.5,010=1.5,011=0.5,100=7.5..111=4.5 mA
// - three separate 3-bit drive fields: bit clock, frame clock, data
`ifndef APDC_CONSTS_VH
`define APDC_CONSTS_VH

`define APDC_ADDR_W            8
`define APDC_DATA_W            16
`define APDC_WORD_BITS         5'h18

`define APDC_OFS_SOFTWARE_RESET        8'h00
`define APDC_OFS_POWER_MODE_CONTROL    8'h0F
`define APDC_OFS_OUTPUT_DRIVE_STRENGTH 8'h11
`define APDC_OFS_DATA_DRIVER_SLEEP     8'h52

`define APDC_RST_BIT           0
`define APDC_SLEEP_LSB         0
`define APDC_SLEEP_MSB         7
`define APDC_DEEP_BIT          8
`define APDC_FULL_BIT          9
`define APDC_PINCFG_LSB        10
`define APDC_PINCFG_MSB        11
`define APDC_DRV_LCLK_LSB      0
`define APDC_DRV_FRAME_LSB     4
`define APDC_DRV_DAT_LSB       8
`define APDC_DDMODE_BIT        0

`define APDC_POWER_MODE_RESET  16'h0000
`define APDC_DRIVE_RESET       16'h0000
`define APDC_DDMODE_RESET      1'h0
`define APDC_PINCFG_FULL       2'h0
`define APDC_PINCFG_DEEP       2'h2

`endif

// file: apdc_power_ctrl.v
// power-mode and output-drive control behind the serial configuration port
// assumes sclk, sdata, csn_n and power_down_pin are synchronous to clk, and
// sclk is slower than clk/2 so every rising edge is seen
// the port is write-only: state shows only on the registered outputs,
// which follow a register write or a pin change one clk later
// nothing is latched from the pin, so releasing it wakes the block at once
`include "apdc_consts.vh"
`default_nettype none

module apdc_power_ctrl #(
  parameter CHANNELS = 8
) (
  input  wire                clk,
  input  wire                srst,
  input  wire                sclk,
  input  wire                sdata,
  input  wire                csn_n,
  input  wire                power_down_pin,
  output reg  [CHANNELS-1:0] channel_sleep,
  output reg                 deep_sleep,
  output reg                 full_power_down,
  output reg                 bandgap_on,
  output reg                 lclk_oe,
  output reg                 frame_clock_out_oe,
  output reg  [CHANNELS-1:0] data_driver_on,
  output reg  [CHANNELS-1:0] data_oe,
  output reg  [CHANNELS-1:0] data_force_zero,
  output reg  [2:0]          lclk_drive_code,
  output reg  [2:0]          frame_drive_code,
  output reg  [2:0]          data_drive_code,
  output reg  [3:0]          lclk_drive_half_ma,
  output reg  [3:0]          frame_drive_half_ma,
  output reg  [3:0]          data_drive_half_ma
);

  // drive current in half-milliamp steps; not monotonic in the code, hence a table
  function [3:0] drive_half_ma;
    input [2:0] code;
    begin
      case (code)
        3'h0: drive_half_ma = 4'h7;
        3'h1: drive_half_ma = 4'h5;
        3'h2: drive_half_ma = 4'h3;
        3'h3: drive_half_ma = 4'h1;
        3'h4: drive_half_ma = 4'hF;
        3'h5: drive_half_ma = 4'hD;
        3'h6: drive_half_ma = 4'hB;
        3'h7: drive_half_ma = 4'h9;
        default: drive_half_ma = 4'h7;
      endcase
    end
  endfunction

  // output values while srst is high: awake, everything driving, 3.5 mA
  localparam [2:0]       CODE_RESET = 3'h0;
  localparam [3:0]       HALF_MA_RESET = 4'h7;
  localparam [CHANNELS-1:0] LANES_ON = {CHANNELS{1'b1}};
  localparam [CHANNELS-1:0] LANES_OFF = {CHANNELS{1'b0}};

  reg  [23:0]            shift;
  reg  [4:0]             bit_count;
  reg                    sclk_prev;
  reg  [15:0]            power_mode_control;
  reg  [15:0]            output_drive_strength;
  reg                    data_driver_sleep_behaviour;

  wire                   sclk_rise = sclk & ~sclk_prev;
  wire [23:0]            next_shift = {shift[22:0], sdata};
  wire                   word_done = ~csn_n & sclk_rise
                                     & (bit_count == `APDC_WORD_BITS - 5'h01);
  wire [7:0]             wr_addr = next_shift[23:16];
  wire [15:0]            wr_data = next_shift[15:0];
  wire                   sw_reset = word_done & (wr_addr == `APDC_OFS_SOFTWARE_RESET)
                                    & wr_data[`APDC_RST_BIT];

  wire [4:0]             next_bit_count = word_done ? 5'h00 : bit_count + 5'h01;

  // sclk idles low, so a low reset value gives no false edge after reset
  always @(posedge clk) begin
    if (srst) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      shift <= 24'h000000;
    end else if (~csn_n & sclk_rise) begin
      shift <= next_shift;
    end
  end

  // deselect drops a partial word
  always @(posedge clk) begin
    if (srst) begin
      bit_count <= 5'h00;
    end else if (csn_n) begin
      bit_count <= 5'h00;
    end else if (sclk_rise) begin
      // longer frames are cut into 24-bit words
      bit_count <= next_bit_count;
    end
  end

  wire                   wr_power = word_done & (wr_addr == `APDC_OFS_POWER_MODE_CONTROL);
  wire                   wr_drive = word_done & (wr_addr == `APDC_OFS_OUTPUT_DRIVE_STRENGTH);
  wire                   wr_ddmode = word_done & (wr_addr == `APDC_OFS_DATA_DRIVER_SLEEP);

  // reset bit is never stored, so it reads back cleared at once
  // unmapped addresses match none of the strobes and are dropped
  always @(posedge clk) begin
    if (srst || sw_reset) begin
      power_mode_control <= `APDC_POWER_MODE_RESET;
    end else if (wr_power) begin
      power_mode_control <= wr_data;
    end
  end

  always @(posedge clk) begin
    if (srst || sw_reset) begin
      output_drive_strength <= `APDC_DRIVE_RESET;
    end else if (wr_drive) begin
      output_drive_strength <= wr_data;
    end
  end

  always @(posedge clk) begin
    if (srst || sw_reset) begin
      data_driver_sleep_behaviour <= `APDC_DDMODE_RESET;
    end else if (wr_ddmode) begin
      data_driver_sleep_behaviour <= wr_data[`APDC_DDMODE_BIT];
    end
  end

  wire [1:0] power_pin_function_select =
    power_mode_control[`APDC_PINCFG_MSB:`APDC_PINCFG_LSB];
  wire [CHANNELS-1:0] channel_light_sleep =
    power_mode_control[`APDC_SLEEP_LSB+CHANNELS-1:`APDC_SLEEP_LSB];

  // pin requests are all-channel only
  wire pin_light = power_down_pin & power_pin_function_select[0];
  wire pin_deep  = power_down_pin
                   & (power_pin_function_select == `APDC_PINCFG_DEEP);
  wire pin_full  = power_down_pin
                   & (power_pin_function_select == `APDC_PINCFG_FULL);

  wire next_full  = power_mode_control[`APDC_FULL_BIT] | pin_full;
  wire next_deep  = (power_mode_control[`APDC_DEEP_BIT] | pin_deep) & ~next_full;
  wire [CHANNELS-1:0] next_light =
    (channel_light_sleep | {CHANNELS{pin_light}}) & ~{CHANNELS{next_deep | next_full}};
  wire [CHANNELS-1:0] next_quiet = next_light | {CHANNELS{next_deep}};

  wire                   next_bandgap = ~next_full;
  wire                   next_clk_oe = ~next_full;
  wire [CHANNELS-1:0]    next_data_on =
    ~{CHANNELS{next_full}} & ({CHANNELS{data_driver_sleep_behaviour}} | ~next_quiet);
  wire [CHANNELS-1:0]    next_data_zero =
    ~{CHANNELS{next_full}} & {CHANNELS{data_driver_sleep_behaviour}} & next_quiet;

  wire [2:0]             lclk_field =
    output_drive_strength[`APDC_DRV_LCLK_LSB+2:`APDC_DRV_LCLK_LSB];
  wire [2:0]             frame_field =
    output_drive_strength[`APDC_DRV_FRAME_LSB+2:`APDC_DRV_FRAME_LSB];
  wire [2:0]             data_field =
    output_drive_strength[`APDC_DRV_DAT_LSB+2:`APDC_DRV_DAT_LSB];
  wire [3:0]             next_lclk_half_ma = drive_half_ma(lclk_field);
  wire [3:0]             next_frame_half_ma = drive_half_ma(frame_field);
  wire [3:0]             next_data_half_ma = drive_half_ma(data_field);

  // power state; priority is already settled in the next_ wires
  always @(posedge clk) begin
    if (srst) begin
      channel_sleep <= LANES_OFF;
    end else begin
      channel_sleep <= next_light;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      deep_sleep <= 1'b0;
    end else begin
      deep_sleep <= next_deep;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      full_power_down <= 1'b0;
    end else begin
      full_power_down <= next_full;
    end
  end

  // band-gap restart is the slow part of waking, so only full power-down stops it
  always @(posedge clk) begin
    if (srst) begin
      bandgap_on <= 1'b1;
    end else begin
      bandgap_on <= next_bandgap;
    end
  end

  // clocks keep running in both sleeps so the receiver stays locked
  // full power-down lets the receiver lose lock; that is the price of the band-gap stop
  always @(posedge clk) begin
    if (srst) begin
      lclk_oe <= 1'b1;
    end else begin
      lclk_oe <= next_clk_oe;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      frame_clock_out_oe <= 1'b1;
    end else begin
      frame_clock_out_oe <= next_clk_oe;
    end
  end

  // driver power and output enable move together; a powered driver never floats
  always @(posedge clk) begin
    if (srst) begin
      data_driver_on <= LANES_ON;
    end else begin
      data_driver_on <= next_data_on;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      data_oe <= LANES_ON;
    end else begin
      data_oe <= next_data_on;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      data_force_zero <= LANES_OFF;
    end else begin
      data_force_zero <= next_data_zero;
    end
  end

  // drive codes and currents change together, one clk after the write
  always @(posedge clk) begin
    if (srst) begin
      lclk_drive_code <= CODE_RESET;
    end else begin
      lclk_drive_code <= lclk_field;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      lclk_drive_half_ma <= HALF_MA_RESET;
    end else begin
      lclk_drive_half_ma <= next_lclk_half_ma;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      frame_drive_code <= CODE_RESET;
    end else begin
      frame_drive_code <= frame_field;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      frame_drive_half_ma <= HALF_MA_RESET;
    end else begin
      frame_drive_half_ma <= next_frame_half_ma;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      data_drive_code <= CODE_RESET;
    end else begin
      data_drive_code <= data_field;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      data_drive_half_ma <= HALF_MA_RESET;
    end else begin
      data_drive_half_ma <= next_data_half_ma;
    end
  end

endmodule

`default_nettype wire

// file: apdc_power_checker_assertions.sv
// checker for the power-mode block, bound to its ports
// assumes one clk domain with srst
`default_nettype none
module apdc_power_checker #(
  parameter CHANNELS = 8
) (
  input wire logic                clk,
  input wire logic                srst,
  input wire logic                deep_sleep,
  input wire logic                full_power_down,
  input wire logic                bandgap_on,
  input wire logic                lclk_oe,
  input wire logic                frame_clock_out_oe,
  input wire logic [CHANNELS-1:0] channel_sleep,
  input wire logic [CHANNELS-1:0] data_oe,
  input wire logic [CHANNELS-1:0] data_driver_on,
  input wire logic [CHANNELS-1:0] data_force_zero,
  input wire logic [2:0]          lclk_drive_code,
  input wire logic [2:0]          data_drive_code,
  input wire logic [3:0]          lclk_drive_half_ma,
  input wire logic [3:0]          data_drive_half_ma
);
  function automatic logic [3:0] ma(input logic [2:0] c);
    return c[2] ? 4'hF - {1'b0, c[1:0], 1'b0} : 4'h7 - {c, 1'b0};
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_band_gap_off: assert property (bandgap_on == !full_power_down)
    else $error("band-gap state wrong");
  a_full_clk_hiz: assert property (full_power_down |-> !lclk_oe && !frame_clock_out_oe
    && data_oe == '0) else $error("drivers on in power-down");
  a_deep_clk_run: assert property (deep_sleep |-> lclk_oe && frame_clock_out_oe)
    else $error("clock drivers off in deep sleep");
  a_deep_data_same: assert property (deep_sleep |-> data_oe == data_driver_on
    && (data_oe == '0 || data_force_zero == '1)) else $error("data drivers wrong in sleep");
  a_full_wins: assert property (full_power_down |-> !deep_sleep && channel_sleep == '0)
    else $error("lighter state beside power-down");
  a_lclk_current: assert property (lclk_drive_half_ma == ma(lclk_drive_code))
    else $error("bit clock current wrong");
  a_data_current: assert property (data_drive_half_ma == ma(data_drive_code))
    else $error("data current wrong");
  a_awake_data_on: assert property (!full_power_down && !deep_sleep && channel_sleep == '0
    |-> data_oe == '1 && data_force_zero == '0) else $error("data off while awake");
  c_deep: cover property (deep_sleep);
  c_full: cover property (full_power_down);
  c_light: cover property (channel_sleep == '1);
endmodule
bind apdc_power_ctrl apdc_power_checker #(.CHANNELS(CHANNELS)) i_apdc_power_checker (
  .clk(clk), .srst(srst), .deep_sleep(deep_sleep), .full_power_down(full_power_down),
  .bandgap_on(bandgap_on), .lclk_oe(lclk_oe), .frame_clock_out_oe(frame_clock_out_oe),
  .channel_sleep(channel_sleep), .data_oe(data_oe), .data_driver_on(data_driver_on),
  .data_force_zero(data_force_zero), .lclk_drive_code(lclk_drive_code),
  .data_drive_code(data_drive_code), .lclk_drive_half_ma(lclk_drive_half_ma),
  .data_drive_half_ma(data_drive_half_ma));
`default_nettype wire

// file: apdc_host_model.sv
// serial configuration host: 24-bit words, address then data, msb first
// assumes the bench clk; lines change just after a clk edge
`default_nettype none
module apdc_host_model (
  input  wire logic clk,
  output var logic  sclk,
  output var logic  sdata,
  output var logic  csn_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    csn_n = 1'b1;
  end
  // hold stretches each sclk phase, so slow and prompt hosts both occur
  task automatic send(input logic [23:0] w, input int hold);
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk);
      csn_n <= 1'b0;
      sclk <= 1'b0;
      sdata <= w[i];
      repeat (hold) @(posedge clk);
      sclk <= 1'b1;
      repeat (hold) @(posedge clk);
    end
    csn_n <= 1'b1;
    sclk <= 1'b0;
    sdata <= ~sdata;
  endtask
endmodule
`default_nettype wire

// file: adc_power_mode_and_lvds_drive_ctrl_bench.sv
// self-checking bench for the power-mode and drive control block
// assumes host model and checker compiled first
`default_nettype none
module adc_power_mode_and_lvds_drive_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic power_down_pin = 1'b0;
  wire sclk, sdata, csn_n, deep_sleep, full_power_down, bandgap_on, lclk_oe, frame_clock_out_oe;
  wire [7:0] channel_sleep, data_oe, data_driver_on, data_force_zero;
  wire [2:0] lclk_drive_code, frame_drive_code, data_drive_code;
  wire [3:0] lclk_drive_half_ma, frame_drive_half_ma, data_drive_half_ma;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 19655;
  always #12.5 clk = ~clk;
  apdc_power_ctrl i_apdc_power_ctrl (.clk(clk), .srst(srst), .sclk(sclk), .sdata(sdata),
    .csn_n(csn_n), .power_down_pin(power_down_pin), .channel_sleep(channel_sleep),
    .deep_sleep(deep_sleep), .full_power_down(full_power_down), .bandgap_on(bandgap_on),
    .lclk_oe(lclk_oe), .frame_clock_out_oe(frame_clock_out_oe), .data_oe(data_oe),
    .data_driver_on(data_driver_on), .data_force_zero(data_force_zero),
    .lclk_drive_code(lclk_drive_code), .frame_drive_code(frame_drive_code),
    .data_drive_code(data_drive_code), .lclk_drive_half_ma(lclk_drive_half_ma),
    .frame_drive_half_ma(frame_drive_half_ma), .data_drive_half_ma(data_drive_half_ma));
  apdc_host_model i_apdc_host_model (.clk(clk), .sclk(sclk), .sdata(sdata), .csn_n(csn_n));
  function automatic logic [3:0] ma(input logic [2:0] c);
    return c[2] ? 4'hF - {1'b0, c[1:0], 1'b0} : 4'h7 - {c, 1'b0};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // outputs settle two edges after the last bit, so three is enough
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_apdc_host_model.send({a, d}, 1 + ($random(seed) & 1));
    repeat (3) @(posedge clk);
  endtask
  task automatic pin(input logic v);
    @(posedge clk);
    power_down_pin <= v;
    repeat (3) @(posedge clk);
  endtask
  task automatic conclude;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    conclude;
  end
  initial begin
    logic [7:0] r;
    logic [2:0] c;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({data_oe, lclk_drive_half_ma}, 32'hFF7);
    pin(1'b1);
    chk({full_power_down, bandgap_on, lclk_oe, frame_clock_out_oe}, 32'h8);
    pin(1'b0);
    wr(8'h52, 16'h0001);
    wr(8'h0F, 16'h0800);
    pin(1'b1);
    chk({deep_sleep, lclk_oe, data_oe, data_force_zero}, 32'h3FFFF);
    wr(8'h0F, 16'h0400);
    chk({deep_sleep, channel_sleep, data_force_zero}, 32'hFFFF);
    pin(1'b0);
    $display("test pin modes done");
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(8'h0F, {8'h00, r});
      chk({channel_sleep, data_force_zero}, {16'h0, r, r});
    end
    wr(8'h0F, 16'h0300);
    wr(8'h33, 16'h0000);
    chk({full_power_down, deep_sleep, lclk_oe}, 32'h4);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(8'h11, {5'h00, ~c, 1'b0, c + 3'h1, 1'b0, c});
      chk({lclk_drive_half_ma, frame_drive_half_ma, data_drive_half_ma},
        {20'h0, ma(c), ma(c + 3'h1), ma(~c)});
      chk({lclk_drive_code, frame_drive_code, data_drive_code}, {23'h0, c, c + 3'h1, ~c});
    end
    $display("test drive codes done");
    wr(8'h00, 16'h0001);
    chk({full_power_down, lclk_drive_code, data_drive_code}, 32'h0);
    wr(8'h0F, 16'h0100);
    chk({deep_sleep, data_oe, data_driver_on}, 32'h10000);
    pin(1'b1);
    chk({full_power_down, deep_sleep}, 32'h2);
    $display("test soft reset done");
    conclude;
  end
endmodule
`default_nettype wire
